//--- shared/ccs_defs.vh
// How it works
// - OPC command sets event bit 0 once all pending operations finish.
// - Event bit 0 enabled and service enable bit 5 raise the summary bit.
// - OPC after initiate stays clear until the engine is idle again.
// - OPC query queues ASCII 1 only after pending operations finish.
// - Queued reply sets message-available bit 4; enabled, it raises summary.
// - OPC query after initiate withholds its reply until engine is idle.
// - OPC query counts as unfinished until its reply sits in the queue.
// - Option query reports each slot's module code, or NONE when empty.
// - Four setup stores, index 0 to 3, for save and recall of settings.
// - A failed recall reloads that store with preset defaults.
// - Reset restores defaults, drops pending commands, cancels OPC responses.
// - Bus trigger acts only while the bus is the arm source.
// - Self-test checksums program memory, queues 0 on pass, 1 on fail.
// - Wait-to-continue holds later commands until overlapped operations end.
// - Only initiate, continuous on and bus trigger are overlapped.
// - Initiate is complete only once the engine is idle again.
// - After trigger, wait holds until the sequencer pointer has settled.
// - Message-available clears whenever the output queue becomes empty.
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

`define CCS_AW          8
`define CCS_DW          32
`define CCS_A_CMD       8'h00
`define CCS_A_ESR       8'h04
`define CCS_A_ESE       8'h08
`define CCS_A_SRE       8'h0c
`define CCS_A_STB       8'h10
`define CCS_A_OQ        8'h14
`define CCS_A_SET       8'h18
`define CCS_A_STAT      8'h1c

`define CCS_C_OPC       4'h1
`define CCS_C_OPCQ      4'h2
`define CCS_C_OPT       4'h3
`define CCS_C_SAV       4'h4
`define CCS_C_RCL       4'h5
`define CCS_C_RST       4'h6
`define CCS_C_TRG       4'h7
`define CCS_C_TST       4'h8
`define CCS_C_WAI       4'h9
`define CCS_C_INIT      4'ha
`define CCS_C_CONT_ON   4'hb
`define CCS_C_CONT_OFF  4'hc

`define CCS_CMD_W       6
`define CCS_FIFO_AW     3
`define CCS_OQ_AW       2
`define CCS_SET_W       16
`define CCS_SET_ARMBUS  0
`define CCS_SET_PRESET  16'h0000
`define CCS_OQ_W        16
`define CCS_ASCII_0     16'h0030
`define CCS_ASCII_1     16'h0031
`define CCS_NONE_CODE   16'h0000
`define CCS_ROM_N       4'h8
`define CCS_ROM_SUM     8'h5a
`define CCS_STB_MAV     4
`define CCS_STB_ESB     5
`define CCS_STB_MSS     6

`endif

//--- rtl/ccs_cmd_fifo.v
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"

module ccs_cmd_fifo
(
    input  wire                    clk_in,
    input  wire                    rst_in,
    input  wire                    flush_in,
    input  wire                    push_in,
    input  wire [`CCS_CMD_W-1:0]   push_data_in,
    input  wire                    pop_in,
    output wire [`CCS_CMD_W-1:0]   pop_data_out,
    output wire                    empty_out,
    output wire                    full_out
);
    reg [`CCS_CMD_W-1:0]   mem_q [0:(1<<`CCS_FIFO_AW)-1];
    reg [`CCS_FIFO_AW:0]   wr_q;
    reg [`CCS_FIFO_AW:0]   rd_q;

    assign empty_out    = (wr_q == rd_q);
    assign full_out     = (wr_q[`CCS_FIFO_AW-1:0] == rd_q[`CCS_FIFO_AW-1:0])
                          && (wr_q[`CCS_FIFO_AW] != rd_q[`CCS_FIFO_AW]);
    assign pop_data_out = mem_q[rd_q[`CCS_FIFO_AW-1:0]];

    always @(posedge clk_in)
    begin
        if (rst_in || flush_in)
        begin
            wr_q <= {(`CCS_FIFO_AW+1){1'b0}};
            rd_q <= {(`CCS_FIFO_AW+1){1'b0}};
        end
        else
        begin
            if (push_in && !full_out)
            begin
                mem_q[wr_q[`CCS_FIFO_AW-1:0]] <= push_data_in;
                wr_q <= wr_q + 1'b1;
            end
            if (pop_in && !empty_out)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- rtl/ccs_top.v
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"

module ccs_top
(
    input  wire                    clk_in,
    input  wire                    rst_in,
    input  wire [`CCS_AW-1:0]      addr_in,
    input  wire [`CCS_DW-1:0]      wdata_in,
    input  wire                    wr_in,
    input  wire                    rd_in,
    output reg  [`CCS_DW-1:0]      rdata_out,
    input  wire                    meas_idle_in,
    input  wire                    trig_settled_in,
    input  wire [`CCS_OQ_W-1:0]    slot1_code_in,
    input  wire [`CCS_OQ_W-1:0]    slot2_code_in,
    output reg                     init_out,
    output reg                     cont_on_out,
    output reg                     bus_trig_out,
    output reg                     abort_out,
    output reg  [`CCS_SET_W-1:0]   settings_out,
    output reg                     srq_out
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_WAI  = 3'h1;
    localparam [2:0] S_OPCQ = 3'h2;
    localparam [2:0] S_TST  = 3'h3;
    localparam [2:0] S_OPT  = 3'h4;

    // Program memory image for the checksum
    function [7:0] rom_byte;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: rom_byte = 8'h12;
                3'h1: rom_byte = 8'h34;
                3'h2: rom_byte = 8'h56;
                3'h3: rom_byte = 8'h78;
                3'h4: rom_byte = 8'h9a;
                3'h5: rom_byte = 8'hbc;
                3'h6: rom_byte = 8'hde;
                default: rom_byte = 8'h12;
            endcase
        end
    endfunction

    // Even parity guard stored beside each saved setup
    function parity;
        input [`CCS_SET_W-1:0] v;
        begin
            parity = ^v;
        end
    endfunction

    reg  [2:0]               state_q;
    reg  [3:0]               step_q;
    reg  [7:0]               sum_q;
    reg                      opc_pend_q;
    reg                      init_busy_q;
    reg                      left_idle_q;
    reg                      trg_busy_q;
    reg                      esr_opc_q;
    reg  [7:0]               ese_q;
    reg  [7:0]               sre_q;
    reg  [`CCS_SET_W:0]      setup_q [0:3];
    reg  [`CCS_OQ_W-1:0]     oq_q [0:(1<<`CCS_OQ_AW)-1];
    reg  [`CCS_OQ_AW:0]      oq_wr_q;
    reg  [`CCS_OQ_AW:0]      oq_rd_q;

    wire [`CCS_CMD_W-1:0]    fifo_dout;
    wire                     fifo_empty;
    wire                     fifo_full;
    wire [3:0]               cur_code = fifo_dout[3:0];
    wire [1:0]               cur_arg  = fifo_dout[5:4];
    wire                     cmd_wr   = wr_in && (addr_in == `CCS_A_CMD);
    wire                     rst_cmd  = cmd_wr && (wdata_in[3:0] == `CCS_C_RST);
    wire                     ovl_busy = init_busy_q | trg_busy_q;
    wire                     pop_cmd  = (state_q == S_IDLE) && !fifo_empty && !rst_cmd;
    wire                     oq_empty = (oq_wr_q == oq_rd_q);
    wire                     oq_full  = (oq_wr_q[`CCS_OQ_AW-1:0] == oq_rd_q[`CCS_OQ_AW-1:0])
                                        && (oq_wr_q[`CCS_OQ_AW] != oq_rd_q[`CCS_OQ_AW]);
    wire                     oq_pop   = rd_in && (addr_in == `CCS_A_OQ) && !oq_empty;
    wire                     esb      = esr_opc_q & ese_q[0];
    wire [7:0]               stb_low  = {2'b00, esb, !oq_empty, 4'h0};
    wire                     mss      = |(stb_low & sre_q & 8'hbf);
    wire [`CCS_SET_W:0]      preset_w = {parity(`CCS_SET_PRESET), `CCS_SET_PRESET};

    reg                      oq_push;
    reg  [`CCS_OQ_W-1:0]     oq_data;

    always @*
    begin
        oq_push = 1'b0;
        oq_data = `CCS_ASCII_1;
        if (!oq_full && !rst_cmd)
        begin
            case (state_q)
                S_OPCQ:
                begin
                    oq_push = !ovl_busy;
                    oq_data = `CCS_ASCII_1;
                end
                S_TST:
                begin
                    oq_push = (step_q == `CCS_ROM_N);
                    oq_data = (sum_q == `CCS_ROM_SUM) ? `CCS_ASCII_0 : `CCS_ASCII_1;
                end
                S_OPT:
                begin
                    oq_push = 1'b1;
                    if (step_q == 4'h0)
                        oq_data = slot1_code_in;
                    else
                        oq_data = slot2_code_in;
                end
                default:
                begin
                    oq_push = 1'b0;
                    oq_data = `CCS_ASCII_1;
                end
            endcase
        end
    end

    ccs_cmd_fifo u_fifo
    (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .flush_in     (rst_cmd),
        .push_in      (cmd_wr && !rst_cmd),
        .push_data_in (wdata_in[`CCS_CMD_W-1:0]),
        .pop_in       (pop_cmd),
        .pop_data_out (fifo_dout),
        .empty_out    (fifo_empty),
        .full_out     (fifo_full)
    );

    // Output queue; a read pops one reply
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            oq_wr_q <= {(`CCS_OQ_AW+1){1'b0}};
            oq_rd_q <= {(`CCS_OQ_AW+1){1'b0}};
        end
        else
        begin
            if (oq_push)
            begin
                oq_q[oq_wr_q[`CCS_OQ_AW-1:0]] <= oq_data;
                oq_wr_q <= oq_wr_q + 1'b1;
            end
            if (oq_pop)
                oq_rd_q <= oq_rd_q + 1'b1;
        end
    end

    // Command executor
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_q      <= S_IDLE;
            step_q       <= 4'h0;
            sum_q        <= 8'h00;
            opc_pend_q   <= 1'b0;
            init_busy_q  <= 1'b0;
            left_idle_q  <= 1'b0;
            trg_busy_q   <= 1'b0;
            esr_opc_q    <= 1'b0;
            ese_q        <= 8'h00;
            sre_q        <= 8'h00;
            settings_out <= `CCS_SET_PRESET;
            init_out     <= 1'b0;
            cont_on_out  <= 1'b0;
            bus_trig_out <= 1'b0;
            abort_out    <= 1'b0;
            srq_out      <= 1'b0;
            rdata_out    <= {`CCS_DW{1'b0}};
            setup_q[0]   <= {parity(`CCS_SET_PRESET), `CCS_SET_PRESET};
            setup_q[1]   <= {parity(`CCS_SET_PRESET), `CCS_SET_PRESET};
            setup_q[2]   <= {parity(`CCS_SET_PRESET), `CCS_SET_PRESET};
            setup_q[3]   <= {parity(`CCS_SET_PRESET), `CCS_SET_PRESET};
        end
        else
        begin
            init_out     <= 1'b0;
            bus_trig_out <= 1'b0;
            abort_out    <= 1'b0;
            srq_out      <= mss;

            // Overlapped completion tracking
            if (init_busy_q && !meas_idle_in)
                left_idle_q <= 1'b1;
            if (init_busy_q && left_idle_q && meas_idle_in && !cont_on_out)
                init_busy_q <= 1'b0;
            if (trg_busy_q && trig_settled_in)
                trg_busy_q <= 1'b0;

            // Set wins over the clear from software
            if (wr_in && addr_in == `CCS_A_ESR && wdata_in[0])
                esr_opc_q <= 1'b0;
            if (opc_pend_q && !ovl_busy)
            begin
                esr_opc_q  <= 1'b1;
                opc_pend_q <= 1'b0;
            end
            if (wr_in && addr_in == `CCS_A_ESE)
                ese_q <= wdata_in[7:0];
            if (wr_in && addr_in == `CCS_A_SRE)
                sre_q <= wdata_in[7:0];
            if (wr_in && addr_in == `CCS_A_SET)
                settings_out <= wdata_in[`CCS_SET_W-1:0];

            case (state_q)
                S_IDLE:
                begin
                    if (pop_cmd)
                    begin
                        case (cur_code)
                            `CCS_C_OPC:  opc_pend_q <= 1'b1;
                            `CCS_C_OPCQ: state_q <= S_OPCQ;
                            `CCS_C_WAI:  state_q <= S_WAI;
                            `CCS_C_SAV:
                                setup_q[cur_arg] <= {parity(settings_out), settings_out};
                            `CCS_C_RCL:
                            begin
                                if (parity(setup_q[cur_arg][`CCS_SET_W-1:0])
                                    == setup_q[cur_arg][`CCS_SET_W])
                                    settings_out <= setup_q[cur_arg][`CCS_SET_W-1:0];
                                else
                                begin
                                    setup_q[cur_arg] <= preset_w;
                                    settings_out     <= `CCS_SET_PRESET;
                                end
                            end
                            `CCS_C_TRG:
                            begin
                                if (settings_out[`CCS_SET_ARMBUS])
                                begin
                                    bus_trig_out <= 1'b1;
                                    trg_busy_q   <= 1'b1;
                                end
                            end
                            `CCS_C_INIT:
                            begin
                                init_out    <= 1'b1;
                                init_busy_q <= 1'b1;
                                left_idle_q <= 1'b0;
                            end
                            `CCS_C_CONT_ON:
                            begin
                                init_out    <= 1'b1;
                                cont_on_out <= 1'b1;
                                init_busy_q <= 1'b1;
                                left_idle_q <= 1'b0;
                            end
                            `CCS_C_CONT_OFF: cont_on_out <= 1'b0;
                            `CCS_C_TST:
                            begin
                                state_q <= S_TST;
                                step_q  <= 4'h0;
                                sum_q   <= 8'h00;
                            end
                            `CCS_C_OPT:
                            begin
                                state_q <= S_OPT;
                                step_q  <= 4'h0;
                            end
                            default: state_q <= S_IDLE;
                        endcase
                    end
                end
                S_WAI:
                    if (!ovl_busy)
                        state_q <= S_IDLE;
                S_OPCQ:
                    if (oq_push)
                        state_q <= S_IDLE;
                S_TST:
                begin
                    if (step_q != `CCS_ROM_N)
                    begin
                        sum_q  <= sum_q + rom_byte(step_q[2:0]);
                        step_q <= step_q + 4'h1;
                    end
                    else if (oq_push)
                        state_q <= S_IDLE;
                end
                S_OPT:
                begin
                    if (oq_push)
                    begin
                        step_q <= step_q + 4'h1;
                        if (step_q != 4'h0)
                            state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase

            // Reset acts at once so a stuck wait cannot block it
            if (rst_cmd)
            begin
                state_q      <= S_IDLE;
                opc_pend_q   <= 1'b0;
                init_busy_q  <= 1'b0;
                trg_busy_q   <= 1'b0;
                cont_on_out  <= 1'b0;
                abort_out    <= 1'b1;
                settings_out <= `CCS_SET_PRESET;
            end

            // Register read port
            rdata_out <= {`CCS_DW{1'b0}};
            if (rd_in)
            begin
                case (addr_in)
                    `CCS_A_ESR:  rdata_out <= {31'h0, esr_opc_q};
                    `CCS_A_ESE:  rdata_out <= {24'h0, ese_q};
                    `CCS_A_SRE:  rdata_out <= {24'h0, sre_q};
                    `CCS_A_STB:  rdata_out <= {24'h0, stb_low | {1'b0, mss, 6'h0}};
                    `CCS_A_OQ:
                        if (!oq_empty)
                            rdata_out <= {15'h0, 1'b1, oq_q[oq_rd_q[`CCS_OQ_AW-1:0]]};
                    `CCS_A_SET:  rdata_out <= {16'h0, settings_out};
                    `CCS_A_STAT:
                        rdata_out <= {24'h0, fifo_full, fifo_empty, trg_busy_q,
                                      init_busy_q, opc_pend_q, state_q};
                    default:     rdata_out <= {`CCS_DW{1'b0}};
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/ccs_meas_model.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_meas_model
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       start_in,
    input  wire logic       trig_in,
    input  wire logic [7:0] busy_len_in,
    output var  logic       idle_out,
    output var  logic       settled_out
);
    logic [7:0] busy_q;
    logic [3:0] trig_q;
    // Engine leaves idle the cycle after a start, like a real sweep would
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            busy_q <= 8'h00;
            trig_q <= 4'h0;
        end
        else
        begin
            if (start_in)
                busy_q <= busy_len_in;
            else if (busy_q != 8'h00)
                busy_q <= busy_q - 8'h01;
            if (trig_in)
                trig_q <= 4'hf;
            else if (trig_q != 4'h0)
                trig_q <= trig_q - 4'h1;
        end
    end
    assign idle_out = (busy_q == 8'h00);
    assign settled_out = (trig_q == 4'h1);
endmodule
`default_nettype wire

//--- sim/ccs_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"
module ccs_chk
(
    input wire logic                  clk_in,
    input wire logic                  rst_in,
    input wire logic [`CCS_AW-1:0]    addr_in,
    input wire logic [`CCS_DW-1:0]    wdata_in,
    input wire logic                  wr_in,
    input wire logic                  rd_in,
    input wire logic [`CCS_DW-1:0]    rdata_out,
    input wire logic                  init_out,
    input wire logic                  cont_on_out,
    input wire logic                  bus_trig_out,
    input wire logic                  abort_out,
    input wire logic [`CCS_SET_W-1:0] settings_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    wire logic rst_cmd = wr_in && (addr_in == `CCS_A_CMD) && (wdata_in[3:0] == `CCS_C_RST);
    wire logic set_wr = wr_in && (addr_in == `CCS_A_SET);
    sequence s_rst_cmd;
        rst_cmd;
    endsequence
    sequence s_reset_done;
        abort_out && (settings_out == `CCS_SET_PRESET) && !cont_on_out;
    endsequence
    chk_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data not zero outside read slot");
    chk_rst_abort: assert property (s_rst_cmd |=> s_reset_done)
        else $error("reset command did not abort and preset");
    chk_abort_cause: assert property (abort_out |-> $past(rst_cmd))
        else $error("abort without reset command");
    chk_init_pulse: assert property (init_out |=> !init_out)
        else $error("initiate pulse longer than one cycle");
    chk_trig_pulse: assert property (bus_trig_out |=> !bus_trig_out)
        else $error("bus trigger pulse longer than one cycle");
    chk_trig_arm: assert property (bus_trig_out |-> settings_out[`CCS_SET_ARMBUS])
        else $error("bus trigger while bus is not arm source");
    chk_set_write: assert property (set_wr |=> settings_out == $past(wdata_in[15:0]))
        else $error("settings write not applied");
    chk_cont_start: assert property ($rose(cont_on_out) |-> init_out)
        else $error("continuous on without initiate");
endmodule
bind ccs_top ccs_chk u_chk (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .init_out, .cont_on_out, .bus_trig_out, .abort_out, .settings_out);
`default_nettype wire

//--- sim/ccs_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"
module ccs_top_tb;
    logic                   clk_in = 1'h0;
    logic                   rst_in = 1'h1;
    logic [`CCS_AW-1:0]     addr_in = 8'h00;
    logic [`CCS_DW-1:0]     wdata_in = 32'h0;
    logic                   wr_in = 1'h0;
    logic                   rd_in = 1'h0;
    logic [`CCS_DW-1:0]     rdata_out;
    logic                   meas_idle_in;
    logic                   trig_settled_in;
    logic [15:0]            slot1_code_in = 16'h1234;
    logic [15:0]            slot2_code_in = 16'h0000;
    logic                   init_out;
    logic                   cont_on_out;
    logic                   bus_trig_out;
    logic                   abort_out;
    logic                   srq_out;
    logic [15:0]            settings_out;
    int                     miscompares = 0;
    int                     samples_checked = 0;
    int                     n_init = 0;
    int                     n_trg = 0;
    int                     n_abort = 0;
    always #50 clk_in = ~clk_in;
    ccs_top uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .meas_idle_in(meas_idle_in),
        .trig_settled_in(trig_settled_in), .slot1_code_in(slot1_code_in),
        .slot2_code_in(slot2_code_in), .init_out(init_out), .cont_on_out(cont_on_out),
        .bus_trig_out(bus_trig_out), .abort_out(abort_out), .settings_out(settings_out),
        .srq_out(srq_out));
    ccs_meas_model u_meas (.clk_in(clk_in), .rst_in(rst_in), .start_in(init_out),
        .trig_in(bus_trig_out), .busy_len_in(8'h28), .idle_out(meas_idle_in),
        .settled_out(trig_settled_in));
    always @(posedge clk_in)
    begin
        n_init <= n_init + (init_out === 1'h1);
        n_trg <= n_trg + (bus_trig_out === 1'h1);
        n_abort <= n_abort + (abort_out === 1'h1);
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'h1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        rd_in <= 1'h1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'h0;
        @(negedge clk_in);
        v = rdata_out;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(what, v, exp);
    endtask
    task automatic cmd(input logic [3:0] c, input logic [1:0] arg);
        wr(`CCS_A_CMD, {26'h0, arg, c});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Bounded so a stuck engine model cannot hang the run
    task automatic wait_idle;
        int i;
        i = 0;
        while (meas_idle_in !== 1'h1 && i < 200)
        begin
            @(posedge clk_in);
            i++;
        end
        check("engine idle", {31'h0, meas_idle_in}, 32'h1);
        idle(4);
    endtask
    task automatic t_reset;
        rdc("esr", `CCS_A_ESR, 32'h0);
        rdc("stb", `CCS_A_STB, 32'h0);
        rdc("oq empty", `CCS_A_OQ, 32'h0);
        rdc("unmapped", 8'h20, 32'h0);
        rdc("stat", `CCS_A_STAT, 32'h40);
        wr(`CCS_A_ESE, 32'h1);
        wr(`CCS_A_SRE, 32'h20);
        rdc("ese", `CCS_A_ESE, 32'h1);
    endtask
    task automatic t_opc;
        cmd(`CCS_C_INIT, 2'h0);
        cmd(`CCS_C_OPC, 2'h0);
        idle(4);
        rdc("esr busy", `CCS_A_ESR, 32'h0);
        wait_idle();
        rdc("esr done", `CCS_A_ESR, 32'h1);
        check("srq esb", {31'h0, srq_out}, 32'h1);
        rdc("stb esb", `CCS_A_STB, 32'h60);
        wr(`CCS_A_ESR, 32'h1);
        idle(3);
        check("srq clr", {31'h0, srq_out}, 32'h0);
        wr(`CCS_A_SRE, 32'h10);
    endtask
    task automatic t_opcq;
        cmd(`CCS_C_INIT, 2'h0);
        cmd(`CCS_C_OPCQ, 2'h0);
        idle(4);
        rdc("oq held", `CCS_A_OQ, 32'h0);
        rdc("stb held", `CCS_A_STB, 32'h0);
        wait_idle();
        rdc("stb mav", `CCS_A_STB, 32'h50);
        check("srq mav", {31'h0, srq_out}, 32'h1);
        rdc("oq one", `CCS_A_OQ, 32'h10031);
        rdc("stb empty", `CCS_A_STB, 32'h0);
    endtask
    task automatic t_wai;
        int b;
        b = n_init;
        cmd(`CCS_C_INIT, 2'h0);
        cmd(`CCS_C_WAI, 2'h0);
        cmd(`CCS_C_OPT, 2'h0);
        cmd(`CCS_C_OPCQ, 2'h0);
        cmd(`CCS_C_INIT, 2'h0);
        idle(4);
        check("init held", n_init - b, 32'h1);
        rdc("stb wai", `CCS_A_STB, 32'h0);
        wait_idle();
        idle(6);
        check("init later", n_init - b, 32'h2);
        rdc("opt slot1", `CCS_A_OQ, 32'h11234);
        rdc("opt none", `CCS_A_OQ, 32'h10000);
        rdc("opcq order", `CCS_A_OQ, 32'h10031);
        wait_idle();
    endtask
    task automatic t_trg;
        wr(`CCS_A_SET, 32'h0);
        cmd(`CCS_C_TRG, 2'h0);
        idle(6);
        check("trg off", n_trg, 32'h0);
        wr(`CCS_A_SET, 32'h1);
        cmd(`CCS_C_TRG, 2'h0);
        cmd(`CCS_C_WAI, 2'h0);
        cmd(`CCS_C_OPCQ, 2'h0);
        rdc("trg held", `CCS_A_OQ, 32'h0);
        idle(25);
        check("trg on", n_trg, 32'h1);
        rdc("trg done", `CCS_A_OQ, 32'h10031);
    endtask
    task automatic t_save;
        for (int i = 0; i < 4; i++)
        begin
            wr(`CCS_A_SET, 32'ha0 + i);
            cmd(`CCS_C_SAV, i[1:0]);
            idle(3);
        end
        wr(`CCS_A_SET, 32'h0);
        for (int i = 3; i >= 0; i--)
        begin
            cmd(`CCS_C_RCL, i[1:0]);
            idle(4);
            rdc("recall", `CCS_A_SET, 32'ha0 + i);
        end
    endtask
    task automatic t_tst;
        logic [31:0] v;
        cmd(`CCS_C_TST, 2'h0);
        idle(16);
        rd(`CCS_A_OQ, v);
        check("selftest", v, {15'h0, 1'b1, `CCS_ASCII_0});
    endtask
    task automatic t_rst;
        wr(`CCS_A_SET, 32'hff);
        cmd(`CCS_C_CONT_ON, 2'h0);
        idle(4);
        check("cont on", {31'h0, cont_on_out}, 32'h1);
        cmd(`CCS_C_OPC, 2'h0);
        cmd(`CCS_C_OPCQ, 2'h0);
        cmd(`CCS_C_RST, 2'h0);
        idle(3);
        check("abort", n_abort, 32'h1);
        check("cont off", {31'h0, cont_on_out}, 32'h0);
        rdc("preset", `CCS_A_SET, 32'h0);
        idle(60);
        rdc("esr cancel", `CCS_A_ESR, 32'h0);
        rdc("oq cancel", `CCS_A_OQ, 32'h0);
        cmd(`CCS_C_CONT_ON, 2'h0);
        cmd(`CCS_C_CONT_OFF, 2'h0);
        idle(2);
        check("cont off cmd", {31'h0, cont_on_out}, 32'h0);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        wrap_up();
    end
    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'h0;
        t_reset();
        t_opc();
        t_opcq();
        t_wai();
        t_trg();
        t_save();
        t_tst();
        t_rst();
        wrap_up();
    end
endmodule
`default_nettype wire
